/* File: logic/udfpm_pin_mux.sv */
// How it works
// (RQ1) 16-bit bus: upper pins are data 15-8
// (RQ2) 8-bit bus: upper pins become flags 15-8
// (RQ3) Port 1 selects 7-4 on pins 15,13,11,9
// (RQ4) Port 0 selects 7-4 on pins 14,12,10,8
// (RQ5) Low flag pins carry selects 3-1
// (RQ6) Flag pins 1,0 become slave-select inputs
// (RQ7) Boot samples flag 7 as PLL divisor
// (RQ8) Boot samples flags 6-0 as multiplier
// (RQ9) All pin inputs synchronised before use
// (RQ10) Straps latched at boot end, then held
`timescale 1ns/1ps
`default_nettype none
module udfpm_pin_mux
    import udfpm_pkg::*;
(
    input wire logic clk, // Core clock, 250 MHz
    input wire logic rst, // Synchronous reset, active high
    input wire udfpm_pkg::udfpm_bus_width_t bus_width, // External bus width
    input wire logic port1_enable, // Serial port 1 enabled
    input wire logic port0_enable, // Serial port 0 enabled
    input wire logic boot_active, // High while booting
    input wire logic [7:0] data_hi_out, // Data 15-8 to drive
    input wire logic data_hi_drive, // Bus drives data 15-8
    output logic [7:0] data_hi_in, // Data 15-8 sampled
    input wire logic [7:0] gp_flag_hi_out, // Flags 15-8 to drive
    input wire logic [7:0] gp_flag_hi_dir, // Flags 15-8 output when high
    output logic [7:0] gp_flag_hi_in, // Flags 15-8 sampled
    input wire logic [7:0] gp_flag_lo_out, // Flags 7-0 to drive
    input wire logic [7:0] gp_flag_lo_dir, // Flags 7-0 output when high
    output logic [7:0] gp_flag_lo_in, // Flags 7-0 sampled
    input wire logic [3:0] port1_slave_sel_out_hi, // Port 1 selects 7-4
    input wire logic [3:0] port0_slave_sel_out_hi, // Port 0 selects 7-4
    input wire logic [2:0] port1_slave_sel_out_lo, // Port 1 selects 3-1
    input wire logic [2:0] port0_slave_sel_out_lo, // Port 0 selects 3-1
    output logic port1_slave_sel_in, // Port 1 slave select input
    output logic port0_slave_sel_in, // Port 0 slave select input
    output logic pll_input_divisor_strap, // Latched divisor select
    output logic [6:0] pll_multiplier_strap, // Latched multiplier select
    input wire logic [7:0] upper_pin_i, // Upper pins, level in
    output logic [7:0] upper_pin_o, // Upper pins, level out
    output logic [7:0] upper_pin_oe_n, // Upper pins, low drives
    input wire logic [7:0] flag_pin_i, // Flag pins 7-0, level in
    output logic [7:0] flag_pin_o, // Flag pins 7-0, level out
    output logic [7:0] flag_pin_oe_n // Flag pins 7-0, low drives
);
    import udfpm_pkg::*;

    // Pin position of each select; port 1 owns the odd pins, port 0 the even ones
    localparam int unsigned P1_HI_SEL4 = 1;
    localparam int unsigned P1_HI_SEL5 = 3;
    localparam int unsigned P1_HI_SEL6 = 5;
    localparam int unsigned P1_HI_SEL7 = 7;
    localparam int unsigned P0_HI_SEL4 = 0;
    localparam int unsigned P0_HI_SEL5 = 2;
    localparam int unsigned P0_HI_SEL6 = 4;
    localparam int unsigned P0_HI_SEL7 = 6;
    localparam int unsigned P1_LO_SEL1 = 3;
    localparam int unsigned P1_LO_SEL2 = 5;
    localparam int unsigned P1_LO_SEL3 = 7;
    localparam int unsigned P0_LO_SEL1 = 2;
    localparam int unsigned P0_LO_SEL2 = 4;
    localparam int unsigned P0_LO_SEL3 = 6;

    // Registered copy of every pin, input and strap output
    typedef struct packed {
        logic [7:0] up_o;
        logic [7:0] up_oe_n;
        logic [7:0] fl_o;
        logic [7:0] fl_oe_n;
        logic [7:0] dat_in;
        logic [7:0] ghi_in;
        logic [7:0] glo_in;
        logic ss1_in;
        logic ss0_in;
        logic div;
        logic [MUL_W-1:0] mul;
    } udfpm_state_t;

    udfpm_state_t state_ff;
    udfpm_state_t nxt_state;
    udfpm_sync_if sif ();
    logic [7:0] up_sync;
    logic [7:0] fl_sync;

    // One synchroniser covers both pin bytes; controls are on our clock and bypass it
    assign sif.raw = {upper_pin_i, flag_pin_i}; // [RQ9]
    udfpm_sync2 u_sync (
        .clk(clk),
        .rst(rst),
        .sif(sif)
    );
    assign up_sync = sif.synced[15:8];
    assign fl_sync = sif.synced[7:0];

    always_comb begin
        nxt_state = state_ff;

        // Upper byte; boot leaves it alone since no strap lives there
        case (bus_width)
            UDFPM_BUS_16: begin
                nxt_state.up_o = data_hi_out; // [RQ1]
                nxt_state.up_oe_n = {UPPER_W{~data_hi_drive}}; // [RQ1]
                nxt_state.dat_in = up_sync; // [RQ1]
            end
            UDFPM_BUS_8: begin
                nxt_state.up_o = gp_flag_hi_out; // [RQ2]
                nxt_state.up_oe_n = ~gp_flag_hi_dir; // [RQ2]
                nxt_state.ghi_in = up_sync; // [RQ2]
                // Selects win over the flag direction bits of their pins
                if (port1_enable) begin
                    nxt_state.up_o[P1_HI_SEL4] = port1_slave_sel_out_hi[0]; // [RQ3]
                    nxt_state.up_oe_n[P1_HI_SEL4] = 1'b0; // [RQ3]
                    nxt_state.up_o[P1_HI_SEL5] = port1_slave_sel_out_hi[1]; // [RQ3]
                    nxt_state.up_oe_n[P1_HI_SEL5] = 1'b0; // [RQ3]
                    nxt_state.up_o[P1_HI_SEL6] = port1_slave_sel_out_hi[2]; // [RQ3]
                    nxt_state.up_oe_n[P1_HI_SEL6] = 1'b0; // [RQ3]
                    nxt_state.up_o[P1_HI_SEL7] = port1_slave_sel_out_hi[3]; // [RQ3]
                    nxt_state.up_oe_n[P1_HI_SEL7] = 1'b0; // [RQ3]
                end
                if (port0_enable) begin
                    nxt_state.up_o[P0_HI_SEL4] = port0_slave_sel_out_hi[0]; // [RQ4]
                    nxt_state.up_oe_n[P0_HI_SEL4] = 1'b0; // [RQ4]
                    nxt_state.up_o[P0_HI_SEL5] = port0_slave_sel_out_hi[1]; // [RQ4]
                    nxt_state.up_oe_n[P0_HI_SEL5] = 1'b0; // [RQ4]
                    nxt_state.up_o[P0_HI_SEL6] = port0_slave_sel_out_hi[2]; // [RQ4]
                    nxt_state.up_oe_n[P0_HI_SEL6] = 1'b0; // [RQ4]
                    nxt_state.up_o[P0_HI_SEL7] = port0_slave_sel_out_hi[3]; // [RQ4]
                    nxt_state.up_oe_n[P0_HI_SEL7] = 1'b0; // [RQ4]
                end
            end
            default: begin
                // Unknown width: let go of the pins rather than fight the bus
                nxt_state.up_oe_n = {UPPER_W{1'b1}};
            end
        endcase

        // Low flags; straps are read as inputs, so all drivers release in boot
        nxt_state.fl_o = gp_flag_lo_out;
        nxt_state.fl_oe_n = ~gp_flag_lo_dir;
        nxt_state.glo_in = fl_sync;

        // Each port gates its own low selects
        if (port1_enable) begin
            nxt_state.fl_o[P1_LO_SEL1] = port1_slave_sel_out_lo[0]; // [RQ5]
            nxt_state.fl_oe_n[P1_LO_SEL1] = 1'b0; // [RQ5]
            nxt_state.fl_o[P1_LO_SEL2] = port1_slave_sel_out_lo[1]; // [RQ5]
            nxt_state.fl_oe_n[P1_LO_SEL2] = 1'b0; // [RQ5]
            nxt_state.fl_o[P1_LO_SEL3] = port1_slave_sel_out_lo[2]; // [RQ5]
            nxt_state.fl_oe_n[P1_LO_SEL3] = 1'b0; // [RQ5]
        end
        if (port0_enable) begin
            nxt_state.fl_o[P0_LO_SEL1] = port0_slave_sel_out_lo[0]; // [RQ5]
            nxt_state.fl_oe_n[P0_LO_SEL1] = 1'b0; // [RQ5]
            nxt_state.fl_o[P0_LO_SEL2] = port0_slave_sel_out_lo[1]; // [RQ5]
            nxt_state.fl_oe_n[P0_LO_SEL2] = 1'b0; // [RQ5]
            nxt_state.fl_o[P0_LO_SEL3] = port0_slave_sel_out_lo[2]; // [RQ5]
            nxt_state.fl_oe_n[P0_LO_SEL3] = 1'b0; // [RQ5]
        end

        // A slave-select input pin must never be driven from our side
        if (port1_enable) begin
            nxt_state.fl_oe_n[SS_IN_P1_BIT] = 1'b1; // [RQ6]
            nxt_state.ss1_in = fl_sync[SS_IN_P1_BIT]; // [RQ6]
        end else begin
            // A disabled port sees its select idle high
            nxt_state.ss1_in = 1'b1;
        end
        if (port0_enable) begin
            nxt_state.fl_oe_n[SS_IN_P0_BIT] = 1'b1; // [RQ6]
            nxt_state.ss0_in = fl_sync[SS_IN_P0_BIT]; // [RQ6]
        end else begin
            nxt_state.ss0_in = 1'b1;
        end

        // Straps follow the pins for all of boot; the last sample is what stays
        if (boot_active) begin
            nxt_state.fl_oe_n = {FLAG_W{1'b1}};
            nxt_state.div = fl_sync[DIV_BIT]; // [RQ7]
            nxt_state.mul = fl_sync[MUL_W-1:0]; // [RQ8]
        end
        // Outside boot div/mul simply hold the last boot sample [RQ10]
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            // Every pin starts released so nothing fights the board in reset
            state_ff.up_o <= '0;
            state_ff.up_oe_n <= {UPPER_W{1'b1}};
            state_ff.fl_o <= '0;
            state_ff.fl_oe_n <= {FLAG_W{1'b1}};
            state_ff.dat_in <= '0;
            state_ff.ghi_in <= '0;
            state_ff.glo_in <= '0;
            state_ff.ss1_in <= 1'b1;
            state_ff.ss0_in <= 1'b1;
            state_ff.div <= DIV_RESET;
            state_ff.mul <= MUL_RESET;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Every output comes straight from a flop, so pins never glitch on control changes
    assign upper_pin_o = state_ff.up_o;
    assign upper_pin_oe_n = state_ff.up_oe_n;
    assign flag_pin_o = state_ff.fl_o;
    assign flag_pin_oe_n = state_ff.fl_oe_n;
    assign data_hi_in = state_ff.dat_in;
    assign gp_flag_hi_in = state_ff.ghi_in;
    assign gp_flag_lo_in = state_ff.glo_in;
    assign port1_slave_sel_in = state_ff.ss1_in;
    assign port0_slave_sel_in = state_ff.ss0_in;
    assign pll_input_divisor_strap = state_ff.div;
    assign pll_multiplier_strap = state_ff.mul;
endmodule
`default_nettype wire

/* File: common/udfpm_pkg.sv */
package udfpm_pkg;
    localparam int unsigned UPPER_W = 8;
    localparam int unsigned FLAG_W = 8;
    localparam int unsigned SEL_W = 4;
    localparam int unsigned LOW_SEL_W = 3;
    localparam int unsigned MUL_W = 7;
    localparam int unsigned DIV_BIT = 7;
    localparam int unsigned SS_IN_P1_BIT = 1;
    localparam int unsigned SS_IN_P0_BIT = 0;
    localparam logic [MUL_W-1:0] MUL_RESET = 7'h00;
    localparam logic DIV_RESET = 1'b0;

    typedef enum logic {
        UDFPM_BUS_8 = 1'b0,
        UDFPM_BUS_16 = 1'b1
    } udfpm_bus_width_t;
endpackage

/* File: common/udfpm_sync_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Raw pin levels in, synchronised copies out
interface udfpm_sync_if;
    logic [15:0] raw;
    logic [15:0] synced;
    modport src (output raw, input synced);
    modport snk (input raw, output synced);
endinterface
`default_nettype wire

/* File: logic/udfpm_sync2.sv */
`timescale 1ns/1ps
`default_nettype none
// Two-stage synchroniser; the first stage feeds only the second
module udfpm_sync2 (
    input wire logic clk, // Core clock
    input wire logic rst, // Synchronous reset
    udfpm_sync_if.snk sif // Raw and synced pin levels
);
    typedef struct packed {
        logic [15:0] meta;
        logic [15:0] stable;
    } udfpm_sync_state_t;

    udfpm_sync_state_t state_ff;
    udfpm_sync_state_t nxt_state;

    always_comb begin
        nxt_state.meta = sif.raw;
        nxt_state.stable = state_ff.meta;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign sif.synced = state_ff.stable;
endmodule
`default_nettype wire

/* File: test/udfpm_board.sv */
`timescale 1ns/1ps
`default_nettype none
module udfpm_board (
    input wire logic [7:0] o, // Device level
    input wire logic [7:0] oe_n, // Device enable, low drives
    input wire logic [7:0] ext, // Board level
    output logic [7:0] pin // Resolved wire
);
    // Board straps show wherever the device lets go
    assign pin = (~oe_n & o) | (oe_n & ext);
endmodule
`default_nettype wire

/* File: test/udfpm_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module udfpm_asserts
    import udfpm_pkg::*;
(
    input wire logic clk, rst, port1_enable, port0_enable, boot_active, // Controls
    input wire udfpm_pkg::udfpm_bus_width_t bus_width, // Width
    input wire logic [7:0] data_hi_out, flag_pin_i, // Sources
    input wire logic data_hi_drive, port0_slave_sel_in, pll_input_divisor_strap, // Bits
    input wire logic [3:0] port1_slave_sel_out_hi, port0_slave_sel_out_hi, // Selects
    input wire logic [2:0] port1_slave_sel_out_lo, // Selects
    input wire logic [7:0] upper_pin_o, upper_pin_oe_n, flag_pin_o, flag_pin_oe_n, // Pins
    input wire logic [6:0] pll_multiplier_strap // Strap
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_wide_data_drive: assert property (bus_width == UDFPM_BUS_16 && data_hi_drive |=>
        upper_pin_o == $past(data_hi_out) && upper_pin_oe_n == 8'h00) else $error("wide");
    a_port1_upper_sel: assert property (bus_width == UDFPM_BUS_8 && port1_enable |=>
        {upper_pin_o[7], upper_pin_o[5], upper_pin_o[3], upper_pin_o[1]}
        == $past(port1_slave_sel_out_hi)) else $error("p1 upper");
    a_port0_upper_sel: assert property (bus_width == UDFPM_BUS_8 && port0_enable |=>
        {upper_pin_o[6], upper_pin_o[4], upper_pin_o[2], upper_pin_o[0]}
        == $past(port0_slave_sel_out_hi)) else $error("p0 upper");
    a_port1_low_sel: assert property (!boot_active && port1_enable |=>
        {flag_pin_o[7], flag_pin_o[5], flag_pin_o[3]} == $past(port1_slave_sel_out_lo))
        else $error("p1 low");
    a_boot_flag_release: assert property (boot_active |=> flag_pin_oe_n == 8'hFF)
        else $error("boot oe");
    a_strap_track: assert property (boot_active[*5] |->
        {pll_input_divisor_strap, pll_multiplier_strap} == $past(flag_pin_i, 3))
        else $error("strap track");
    a_strap_hold: assert property ((!boot_active)[*2] |=> $stable(pll_multiplier_strap)
        && $stable(pll_input_divisor_strap)) else $error("strap hold");
    a_port0_ss_in: assert property (port0_enable[*4] |->
        port0_slave_sel_in == $past(flag_pin_i[0], 3)) else $error("ss in");
endmodule
`default_nettype wire

/* File: test/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import udfpm_pkg::*;
    logic clk = 0, rst = 1, p1 = 0, p0 = 0, boot = 0, drv = 0, ss1, ss0, div;
    udfpm_bus_width_t bw = UDFPM_BUS_8;
    logic [7:0] dout = 0, hout = 0, hdir = 8'hFF, ext = 0, ui, uo, uoe, fi, fo, foe, dhi, ghi, glo;
    logic [3:0] s1h = 0, s0h = 0;
    logic [2:0] s1l = 0, s0l = 0;
    logic [6:0] mul;
    int mismatches = 0, samples_checked = 0;
    initial forever #2 clk = ~clk;
    udfpm_pin_mux DUT (.clk(clk), .rst(rst), .bus_width(bw), .port1_enable(p1),
        .port0_enable(p0), .boot_active(boot), .data_hi_out(dout), .data_hi_drive(drv),
        .data_hi_in(dhi), .gp_flag_hi_out(hout), .gp_flag_hi_dir(hdir), .gp_flag_hi_in(ghi),
        .gp_flag_lo_out(8'h00), .gp_flag_lo_dir(8'hFF), .gp_flag_lo_in(glo),
        .port1_slave_sel_out_hi(s1h), .port0_slave_sel_out_hi(s0h),
        .port1_slave_sel_out_lo(s1l), .port0_slave_sel_out_lo(s0l),
        .port1_slave_sel_in(ss1), .port0_slave_sel_in(ss0), .pll_input_divisor_strap(div),
        .pll_multiplier_strap(mul), .upper_pin_i(ui), .upper_pin_o(uo), .upper_pin_oe_n(uoe),
        .flag_pin_i(fi), .flag_pin_o(fo), .flag_pin_oe_n(foe));
    udfpm_board up (.o(uo), .oe_n(uoe), .ext(ext), .pin(ui));
    udfpm_board lo (.o(fo), .oe_n(foe), .ext(ext), .pin(fi));
    task automatic w(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %h vs %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic t_wide;
        bw = UDFPM_BUS_16;
        drv = 1;
        dout = 8'hA5;
        w(4);
        chk(uoe, 8'h00);
        chk(dhi, 8'hA5);
        drv = 0;
        ext = 8'h5A;
        w(4);
        chk(uoe, 8'hFF);
        chk(dhi, 8'h5A);
    endtask
    task automatic t_narrow;
        bw = UDFPM_BUS_8;
        hout = 8'h3C;
        w(4);
        chk(uo, 8'h3C);
        chk(ghi, 8'h3C);
        chk(uoe, 8'h00);
        p1 = 1;
        p0 = 1;
        s1h = 4'hA;
        s0h = 4'h6;
        s1l = 3'h5;
        s0l = 3'h2;
        ext = 8'h02;
        w(4);
        chk(uo, 8'h9C);
        chk({fo[7:2], foe[1:0]}, 8'h9B);
        chk({6'h00, ss1, ss0}, 8'h02);
        chk(glo, 8'h9A);
        chk(uoe, 8'h00);
    endtask
    task automatic t_boot;
        boot = 1;
        ext = 8'hB7;
        w(6);
        chk(foe, 8'hFF);
        chk({div, mul}, 8'hB7);
        boot = 0;
        ext = 8'h48;
        w(4);
        chk({div, mul}, 8'hB7);
    endtask
    initial begin
        w(6);
        rst = 0;
        t_wide;
        t_narrow;
        t_boot;
        tally_and_finish;
    end
endmodule
bind udfpm_pin_mux udfpm_asserts chk (.*);
`default_nettype wire
